// *** tb/cabx_execute_props.sv ***
// Concurrent checks on the execute stage, seeing only its ports.
// Assumes it is bound to every cabx_execute instance by the bind below.
module cabx_execute_props #(
  parameter int CALL_CYCLES = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Request side
  input wire cabx_pkg::cabx_req_t req,
  input wire logic in_ready,
  input wire logic status_wr,
  input wire logic [7:0] status_wdata,
  // Result side
  input wire cabx_pkg::cabx_res_t res,
  input wire logic [7:0] status_register
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  wire logic take = req.valid && in_ready;
  wire logic io_blocked = req.io_addr >= 6'h08 && req.io_addr <= 6'h0e;
  wire logic [21:0] br_target = req.pc + {{15{req.offset[6]}}, req.offset} + 22'h000001;

  // --------------------------------------------------------------
  // Sequences
  // --------------------------------------------------------------
  sequence s_take(cabx_pkg::cabx_op_t o);
    take && req.op == o;
  endsequence
  sequence s_one_stall;
    !in_ready ##1 in_ready;
  endsequence

  a_jump_target: assert property (s_take(cabx_pkg::OP_JUMP_VIA_POINTER) |=>
    res.pc_valid && res.pc == {6'h00, $past(req.pointer)}) else $error("pointer jump target wrong");
  a_jump_two_clocks: assert property (s_take(cabx_pkg::OP_JUMP_VIA_POINTER) |=> s_one_stall)
    else $error("pointer jump does not take two clocks");
  a_call_push: assert property (s_take(cabx_pkg::OP_CALL_VIA_POINTER) |=>
    res.push && res.ret_addr == $past(req.pc) + 22'h000001 && res.pc == {6'h00, $past(req.pointer)})
    else $error("pointer call push or target wrong");
  a_call_stall_len: assert property (s_take(cabx_pkg::OP_CALL_VIA_POINTER) |=> (!in_ready) [*2]
    ##1 (in_ready == (CALL_CYCLES == 3))) else $error("pointer call length wrong");
  a_branch_offset: assert property (s_take(cabx_pkg::OP_BRANCH_STATUS_BIT_SET)
    ##0 status_register[req.bit_sel] |=> res.pc_valid && res.pc == $past(br_target))
    else $error("taken branch target wrong");
  a_logic_keeps_ch: assert property (take && req.op inside {cabx_pkg::OP_CONJUNCTION,
    cabx_pkg::OP_DISJUNCTION, cabx_pkg::OP_BITWISE_EXCLUSIVE_DISJUNCTION} |=>
    status_register[0] == $past(status_register[0]) && status_register[5] == $past(status_register[5]))
    else $error("logic op changed carry or half carry");
  a_io_refused: assert property (take && io_blocked && req.op inside {cabx_pkg::OP_IO_BIT_SET_OP,
    cabx_pkg::OP_IO_BIT_CLEAR_OP} |=> res.io_refused && !res.io_wr) else $error("blocked bit op wrote");
  a_sum_one_clock: assert property (s_take(cabx_pkg::OP_SUM) |=>
    res.wr_en && in_ready && res.wr_data == $past(req.rd) + $past(req.rr)) else $error("sum wrong");
  a_cmp_imm_carry: assert property (s_take(cabx_pkg::OP_COMPARE_IMMEDIATE) |=>
    !res.wr_en && status_register[0] == ($past(req.rd) < $past(req.imm))) else $error("compare carry wrong");
  a_skip_flags_kept: assert property (take && !status_wr && req.op inside {cabx_pkg::OP_SKIP_REG_BIT_CLEAR,
    cabx_pkg::OP_SKIP_REG_BIT_SET, cabx_pkg::OP_SKIP_IO_BIT_CLEAR, cabx_pkg::OP_SKIP_IO_BIT_SET}
    |=> $stable(status_register)) else $error("skip changed flags");
endmodule : cabx_execute_props

bind cabx_execute cabx_execute_props #(.CALL_CYCLES(CALL_CYCLES)) i_props (.clk(clk), .arst_n(arst_n),
  .req(req), .in_ready(in_ready), .status_wr(status_wr), .status_wdata(status_wdata), .res(res),
  .status_register(status_register));

// *** tb/tb_cabx_execute.sv ***
// Self-checking bench for the execute stage; inputs change on falling edges.
// Assumes the package and design files are compiled before this file.
module tb_cabx_execute;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic arst_n;
  cabx_pkg::cabx_req_t req;
  logic in_ready;
  logic status_wr;
  logic [7:0] status_wdata;
  cabx_pkg::cabx_res_t res;
  logic [7:0] status_register;
  int miscompares;
  int cmp_count;

  cabx_execute #(.CALL_CYCLES(3)) i_dut (.clk(clk), .arst_n(arst_n), .req(req), .in_ready(in_ready),
    .status_wr(status_wr), .status_wdata(status_wdata), .res(res), .status_register(status_register));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [21:0] exp, input logic [21:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // --------------------------------------------------------------
  // Drivers
  // --------------------------------------------------------------
  // Waits out any stall, so a multi-cycle op is never overrun.
  task automatic issue(input cabx_pkg::cabx_op_t op, input logic [7:0] a, input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clk);
    while (in_ready !== 1'b1 && n < 8) begin
      n++;
      @(negedge clk);
    end
    req.op = op;
    req.rd = a;
    req.rr = b;
    req.imm = b;
    req.valid = 1'b1;
    @(negedge clk);
    req.valid = 1'b0;
  endtask : issue

  task automatic set_status(input logic [7:0] v);
    @(negedge clk);
    status_wr = 1'b1;
    status_wdata = v;
    @(negedge clk);
    status_wr = 1'b0;
    chk("status_load", v, status_register);
  endtask : set_status

  task automatic alu(input cabx_pkg::cabx_op_t op, input logic [7:0] a, b, d, s, input logic w);
    issue(op, a, b);
    chk("wr_en", w, res.wr_en);
    chk("pc_valid", 1'b1, res.pc_valid);
    if (w) chk("wr_data", d, res.wr_data);
    chk("status", s, status_register);
  endtask : alu

  task automatic skip(input cabx_pkg::cabx_op_t op, input logic [7:0] a, b, input logic tw, input logic [21:0] e);
    logic [7:0] s;
    s = status_register;
    req.pc = 22'h000200;
    req.bit_sel = 3'h2;
    req.io_data = a;
    req.next_two_words = tw;
    issue(op, a, b);
    chk("skip_pc", e, res.pc);
    chk("skip_ready", e == 22'h000201, in_ready);
    chk("skip_flags", s, status_register);
  endtask : skip

  // Pairs of branch ops share one flag; k odd flips the sense, except the carry and sign pairs.
  function automatic logic taken(input int k, input logic [7:0] s);
    logic [6:0] f;
    f = {s[7], s[3], s[6], s[5], s[2] ^ s[3], s[0], s[2]};
    return f[k / 2] ^ k[0] ^ (k inside {[2:5]});
  endfunction : taken

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_arith();
    alu(cabx_pkg::OP_SUM, 8'h0f, 8'h01, 8'h10, 8'h20, 1'b1);
    alu(cabx_pkg::OP_SUM, 8'hff, 8'h01, 8'h00, 8'h23, 1'b1);
    alu(cabx_pkg::OP_SUM_CARRY, 8'h7f, 8'h00, 8'h80, 8'h2c, 1'b1);
    alu(cabx_pkg::OP_DIFFERENCE, 8'h00, 8'h01, 8'hff, 8'h35, 1'b1);
    alu(cabx_pkg::OP_DIFFERENCE_IMMEDIATE_BORROW, 8'h10, 8'h00, 8'h0f, 8'h20, 1'b1);
    alu(cabx_pkg::OP_DIFFERENCE_WITH_BORROW, 8'h05, 8'h05, 8'h00, 8'h00, 1'b1);
    alu(cabx_pkg::OP_DIFFERENCE_IMMEDIATE, 8'h80, 8'h01, 8'h7f, 8'h38, 1'b1);
    alu(cabx_pkg::OP_COMPARE_IMMEDIATE, 8'h05, 8'h06, 8'h00, 8'h35, 1'b0);
    alu(cabx_pkg::OP_COMPARE_REGISTERS, 8'h20, 8'h20, 8'h00, 8'h02, 1'b0);
    alu(cabx_pkg::OP_COMPARE_WITH_BORROW, 8'h20, 8'h20, 8'h00, 8'h02, 1'b0);
  endtask : t_arith

  task automatic t_logic();
    set_status(8'h29);
    alu(cabx_pkg::OP_CONJUNCTION, 8'hf0, 8'h80, 8'h80, 8'h35, 1'b1);
    alu(cabx_pkg::OP_BITWISE_EXCLUSIVE_DISJUNCTION, 8'h55, 8'h55, 8'h00, 8'h23, 1'b1);
    alu(cabx_pkg::OP_DISJUNCTION, 8'h01, 8'h02, 8'h03, 8'h21, 1'b1);
    alu(cabx_pkg::OP_BITWISE_CONJUNCTION_IMMEDIATE, 8'h0f, 8'hf0, 8'h00, 8'h23, 1'b1);
    alu(cabx_pkg::OP_BITWISE_DISJUNCTION_IMMEDIATE, 8'h80, 8'h01, 8'h81, 8'h35, 1'b1);
    alu(cabx_pkg::OP_MASK_SET_BITS, 8'h00, 8'h40, 8'h40, 8'h21, 1'b1);
    alu(cabx_pkg::OP_MASK_CLEAR_BITS, 8'hff, 8'h0f, 8'hf0, 8'h35, 1'b1);
    alu(cabx_pkg::OP_ZERO_SIGN_CHECK, 8'h00, 8'h00, 8'h00, 8'h23, 1'b0);
  endtask : t_logic

  task automatic t_pointer();
    req.pc = 22'h3f0000;
    req.pointer = 16'hbeef;
    issue(cabx_pkg::OP_JUMP_VIA_POINTER, 8'h00, 8'h00);
    chk("jump_pc", 22'h00beef, res.pc);
    chk("jump_stall", 1'b0, in_ready);
    req.pc = 22'h000100;
    req.pointer = 16'h1234;
    issue(cabx_pkg::OP_CALL_VIA_POINTER, 8'h00, 8'h00);
    chk("call_pc", 22'h001234, res.pc);
    chk("call_ret", 22'h000101, res.ret_addr);
    chk("call_push", 1'b1, res.push);
    @(negedge clk);
    chk("call_stall", 1'b0, in_ready);
    @(negedge clk);
    chk("call_ready", 1'b1, in_ready);
  endtask : t_pointer

  task automatic t_branches();
    logic [7:0] sv [3] = '{8'h00, 8'hff, 8'h04};
    logic t;
    foreach (sv[i]) begin
      for (int k = 0; k < 14; k++) begin
        set_status(sv[i]);
        req.pc = 22'h000100;
        req.offset = 7'h7e;
        req.bit_sel = 3'h2;
        issue(cabx_pkg::cabx_op_t'(k + int'(cabx_pkg::OP_BRANCH_STATUS_BIT_SET)), 8'h00, 8'h00);
        t = taken(k, sv[i]);
        chk("branch_pc", t ? 22'h0000ff : 22'h000101, res.pc);
        chk("branch_ready", !t, in_ready);
      end
    end
  endtask : t_branches

  task automatic t_io();
    logic [5:0] ad [4] = '{6'h07, 6'h08, 6'h0e, 6'h0f};
    logic bad;
    foreach (ad[i]) begin
      req.io_addr = ad[i];
      req.io_data = 8'hf0;
      req.bit_sel = 3'h3;
      issue(i[0] ? cabx_pkg::OP_IO_BIT_CLEAR_OP : cabx_pkg::OP_IO_BIT_SET_OP, 8'h00, 8'h00);
      bad = ad[i] inside {[6'h08:6'h0e]};
      chk("io_refused", bad, res.io_refused);
      chk("io_wr", !bad, res.io_wr);
      chk("io_addr", ad[i], res.io_addr);
      if (!bad) chk("io_data", i[0] ? 8'hf0 : 8'hf8, res.io_data);
    end
  endtask : t_io

  initial begin
    req = '0;
    status_wr = 1'b0;
    status_wdata = 8'h00;
    arst_n = 1'b0;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    chk("reset_ready", 1'b1, in_ready);
    chk("reset_status", 8'h00, status_register);
    chk("reset_res", 5'h00, {res.wr_en, res.pc_valid, res.push, res.io_wr, res.io_refused});
    t_arith();
    t_logic();
    t_pointer();
    skip(cabx_pkg::OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h33, 1'b1, 22'h000203);
    skip(cabx_pkg::OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h34, 1'b1, 22'h000201);
    skip(cabx_pkg::OP_SKIP_REG_BIT_CLEAR, 8'hfb, 8'hfb, 1'b0, 22'h000202);
    skip(cabx_pkg::OP_SKIP_REG_BIT_SET, 8'hfb, 8'hfb, 1'b1, 22'h000201);
    skip(cabx_pkg::OP_SKIP_IO_BIT_SET, 8'h04, 8'h04, 1'b1, 22'h000203);
    skip(cabx_pkg::OP_SKIP_IO_BIT_CLEAR, 8'h04, 8'h04, 1'b0, 22'h000201);
    t_branches();
    t_io();
    conclude();
  end

  // The whole run needs well under a thousand cycles.
  initial begin
    #50us;
    miscompares++;
    conclude();
  end
endmodule : tb_cabx_execute

// *** verilog/cabx_execute.sv ***
// Execute stage: arithmetic, logic, compare, skip, branch and pointer jumps.
// Assumes operands are read by the decoder and results written back by it.
// Assumes the caller holds a request until in_ready is high; a request shown
// while in_ready is low is ignored, not queued.
module cabx_execute #(
  parameter int CALL_CYCLES = cabx_pkg::CALL_CYC_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Instruction request
  input cabx_pkg::cabx_req_t req,
  output logic in_ready,
  // Status register load from other units
  input wire logic status_wr,
  input wire logic [7:0] status_wdata,
  // Results
  output cabx_pkg::cabx_res_t res,
  output logic [7:0] status_register
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (CALL_CYCLES < 3 || CALL_CYCLES > 4) begin : g_bad_call
    $error("CALL_CYCLES must be 3 or 4");
  end

  // The pointer pair must fit the counter, and the offset must be narrower than it.
  if (cabx_pkg::PC_W < 16 || cabx_pkg::OFF_W >= cabx_pkg::PC_W) begin : g_bad_widths
    $error("PC_W must hold the pointer pair and exceed OFF_W");
  end

  localparam logic [2:0] CALL_CYC = 3'(CALL_CYCLES);

  // ----------------------------------------------------------------
  // Operation classes
  // ----------------------------------------------------------------
  cabx_pkg::cabx_op_t op;
  assign op = req.op;
  // A request counts only on an edge at which in_ready is high.
  wire take = req.valid && in_ready;

  wire is_add = (op == cabx_pkg::OP_SUM) || (op == cabx_pkg::OP_SUM_CARRY);
  wire is_cmp = (op == cabx_pkg::OP_COMPARE_REGISTERS) || (op == cabx_pkg::OP_COMPARE_WITH_BORROW)
             || (op == cabx_pkg::OP_COMPARE_IMMEDIATE);
  wire is_sub = is_cmp || (op == cabx_pkg::OP_DIFFERENCE) || (op == cabx_pkg::OP_DIFFERENCE_IMMEDIATE)
             || (op == cabx_pkg::OP_DIFFERENCE_WITH_BORROW) || (op == cabx_pkg::OP_DIFFERENCE_IMMEDIATE_BORROW);
  wire use_carry = (op == cabx_pkg::OP_SUM_CARRY) || (op == cabx_pkg::OP_DIFFERENCE_WITH_BORROW)
                || (op == cabx_pkg::OP_DIFFERENCE_IMMEDIATE_BORROW) || (op == cabx_pkg::OP_COMPARE_WITH_BORROW);
  wire use_imm = (op == cabx_pkg::OP_DIFFERENCE_IMMEDIATE) || (op == cabx_pkg::OP_DIFFERENCE_IMMEDIATE_BORROW)
              || (op == cabx_pkg::OP_COMPARE_IMMEDIATE) || (op == cabx_pkg::OP_BITWISE_CONJUNCTION_IMMEDIATE)
              || (op == cabx_pkg::OP_BITWISE_DISJUNCTION_IMMEDIATE) || (op == cabx_pkg::OP_MASK_SET_BITS);
  wire is_and = (op == cabx_pkg::OP_CONJUNCTION) || (op == cabx_pkg::OP_BITWISE_CONJUNCTION_IMMEDIATE)
             || (op == cabx_pkg::OP_MASK_CLEAR_BITS) || (op == cabx_pkg::OP_ZERO_SIGN_CHECK);
  wire is_or = (op == cabx_pkg::OP_DISJUNCTION) || (op == cabx_pkg::OP_BITWISE_DISJUNCTION_IMMEDIATE)
            || (op == cabx_pkg::OP_MASK_SET_BITS);
  wire is_xor = (op == cabx_pkg::OP_BITWISE_EXCLUSIVE_DISJUNCTION);
  wire is_logic = is_and || is_or || is_xor;

  // ----------------------------------------------------------------
  // Operand selection
  // ----------------------------------------------------------------
  logic [7:0] opb;
  assign opb = (op == cabx_pkg::OP_MASK_CLEAR_BITS) ? (cabx_pkg::ALL_ONES - req.imm) :
               (op == cabx_pkg::OP_ZERO_SIGN_CHECK) ? req.rd :
               use_imm ? req.imm : req.rr;
  wire cin = use_carry & status_register[cabx_pkg::FLG_C];

  // ----------------------------------------------------------------
  // Adder, subtractor and logic unit
  // ----------------------------------------------------------------
  logic [8:0] sum9;
  logic [8:0] diff9;
  assign sum9 = {1'b0, req.rd} + {1'b0, opb} + {8'h00, cin};
  assign diff9 = {1'b0, req.rd} - {1'b0, opb} - {8'h00, cin};

  logic [7:0] logic_r;
  assign logic_r = is_and ? (req.rd & opb) : is_or ? (req.rd | opb) : (req.rd ^ opb);

  logic [7:0] alu_r;
  assign alu_r = is_add ? sum9[7:0] : is_sub ? diff9[7:0] : logic_r;

  wire a3 = req.rd[3];
  wire b3 = opb[3];
  wire r3 = alu_r[3];
  wire a7 = req.rd[7];
  wire b7 = opb[7];
  wire r7 = alu_r[7];
  // Half carry and overflow are read from operand and result bits, so one
  // adder and one subtractor serve every arithmetic variant.
  wire h_add = (a3 & b3) | (b3 & ~r3) | (~r3 & a3);
  wire h_sub = (~a3 & b3) | (b3 & r3) | (r3 & ~a3);
  wire v_add = (a7 & b7 & ~r7) | (~a7 & ~b7 & r7);
  wire v_sub = (a7 & ~b7 & ~r7) | (~a7 & b7 & r7);

  // Borrow variants keep Z only if it was already set, so a multi-byte
  // compare or subtract reports zero for the whole chain.
  wire zero_raw = (alu_r == 8'h00);
  wire z_new = (use_carry && is_sub) ? (zero_raw & status_register[cabx_pkg::FLG_Z]) : zero_raw;
  wire v_new = is_add ? v_add : is_sub ? v_sub : 1'b0;

  logic [7:0] flags_arith;
  always_comb begin
    flags_arith = status_register;
    flags_arith[cabx_pkg::FLG_Z] = z_new;
    flags_arith[cabx_pkg::FLG_N] = r7;
    flags_arith[cabx_pkg::FLG_V] = v_new;
    flags_arith[cabx_pkg::FLG_S] = r7 ^ v_new;
    if (is_add || is_sub) begin
      flags_arith[cabx_pkg::FLG_C] = is_add ? sum9[8] : diff9[8];
      flags_arith[cabx_pkg::FLG_H] = is_add ? h_add : h_sub;
    end
  end

  // ----------------------------------------------------------------
  // Branch and skip conditions
  // ----------------------------------------------------------------
  wire [7:0] sr = status_register;
  wire sel_status = sr[req.bit_sel];
  wire n_xor_v = sr[cabx_pkg::FLG_N] ^ sr[cabx_pkg::FLG_V];
  wire reg_bit = req.rr[req.bit_sel];
  wire io_bit = req.io_data[req.bit_sel];

  logic br_taken;
  logic is_branch;
  always_comb begin
    is_branch = 1'b1;
    case (op)
      cabx_pkg::OP_BRANCH_STATUS_BIT_SET: br_taken = sel_status;
      cabx_pkg::OP_BRANCH_STATUS_BIT_CLEAR: br_taken = ~sel_status;
      cabx_pkg::OP_BRANCH_UNSIGNED_GE: br_taken = ~sr[cabx_pkg::FLG_C];
      cabx_pkg::OP_BRANCH_UNSIGNED_LT: br_taken = sr[cabx_pkg::FLG_C];
      cabx_pkg::OP_BRANCH_SIGNED_GE: br_taken = ~n_xor_v;
      cabx_pkg::OP_BRANCH_SIGNED_LT: br_taken = n_xor_v;
      cabx_pkg::OP_BRANCH_HALF_CARRY_SET: br_taken = sr[cabx_pkg::FLG_H];
      cabx_pkg::OP_BRANCH_HALF_CARRY_CLEAR: br_taken = ~sr[cabx_pkg::FLG_H];
      cabx_pkg::OP_BRANCH_COPY_FLAG_SET: br_taken = sr[cabx_pkg::FLG_T];
      cabx_pkg::OP_BRANCH_COPY_FLAG_CLEAR: br_taken = ~sr[cabx_pkg::FLG_T];
      cabx_pkg::OP_BRANCH_OVERFLOW_SET: br_taken = sr[cabx_pkg::FLG_V];
      cabx_pkg::OP_BRANCH_OVERFLOW_CLEAR: br_taken = ~sr[cabx_pkg::FLG_V];
      cabx_pkg::OP_BRANCH_IRQ_ENABLED: br_taken = sr[cabx_pkg::FLG_I];
      cabx_pkg::OP_BRANCH_IRQ_DISABLED: br_taken = ~sr[cabx_pkg::FLG_I];
      default: begin
        br_taken = 1'b0;
        is_branch = 1'b0;
      end
    endcase
  end

  logic skip;
  always_comb begin
    case (op)
      cabx_pkg::OP_COMPARE_SKIP_EQUAL: skip = (req.rd == req.rr);
      cabx_pkg::OP_SKIP_REG_BIT_CLEAR: skip = ~reg_bit;
      cabx_pkg::OP_SKIP_REG_BIT_SET: skip = reg_bit;
      cabx_pkg::OP_SKIP_IO_BIT_CLEAR: skip = ~io_bit;
      cabx_pkg::OP_SKIP_IO_BIT_SET: skip = io_bit;
      default: skip = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next program counter and clock count
  // ----------------------------------------------------------------
  // The offset is sign-extended so that a branch may land before or after
  // itself; a target beyond its short reach needs a jump through the pointer.
  wire [cabx_pkg::PC_W-1:0] off_ext = {{(cabx_pkg::PC_W - cabx_pkg::OFF_W){req.offset[cabx_pkg::OFF_W-1]}},
                                       req.offset};
  wire [cabx_pkg::PC_W-1:0] pc_seq = req.pc + cabx_pkg::PC_STEP;
  wire [cabx_pkg::PC_W-1:0] pc_branch = req.pc + off_ext + cabx_pkg::PC_STEP;
  wire [cabx_pkg::PC_W-1:0] pc_skip = req.pc + (req.next_two_words ? cabx_pkg::PC_SKIP2 : cabx_pkg::PC_SKIP1);
  wire [cabx_pkg::PC_W-1:0] pc_ptr = {{(cabx_pkg::PC_W - 16){1'b0}}, req.pointer};
  wire is_jump = (op == cabx_pkg::OP_JUMP_VIA_POINTER);
  wire is_call = (op == cabx_pkg::OP_CALL_VIA_POINTER);

  logic [cabx_pkg::PC_W-1:0] pc_new;
  assign pc_new = (is_jump || is_call) ? pc_ptr : (is_branch && br_taken) ? pc_branch : skip ? pc_skip : pc_seq;

  // A skip costs one clock more per word skipped; taken branches and jumps pay one
  // extra clock for the refetch, and a call pays its stacking clocks on top.
  logic [2:0] cycles;
  assign cycles = is_jump ? cabx_pkg::CYC_TWO :
                  is_call ? CALL_CYC :
                  (is_branch && br_taken) ? cabx_pkg::CYC_TWO :
                  !skip ? cabx_pkg::CYC_ONE :
                  req.next_two_words ? cabx_pkg::CYC_THREE : cabx_pkg::CYC_TWO;

  // ----------------------------------------------------------------
  // Single-bit I/O write
  // ----------------------------------------------------------------
  // A refused bit operation still advances the counter; the caller sees
  // io_refused in place of a write and must use a full-byte access instead.
  wire is_iobit = (op == cabx_pkg::OP_IO_BIT_SET_OP) || (op == cabx_pkg::OP_IO_BIT_CLEAR_OP);
  wire io_blocked = (req.io_addr >= cabx_pkg::IO_NOBIT_LO) && (req.io_addr <= cabx_pkg::IO_NOBIT_HI);
  logic [7:0] bit_mask;
  assign bit_mask = 8'h01 << req.bit_sel;
  logic [7:0] io_new;
  assign io_new = (op == cabx_pkg::OP_IO_BIT_SET_OP) ? (req.io_data | bit_mask) : (req.io_data & ~bit_mask);

  // ----------------------------------------------------------------
  // Write-back classes
  // ----------------------------------------------------------------
  // Compares and the zero-sign check only report flags; they must leave the
  // destination register alone.
  wire writes_flags = is_add || is_sub || is_logic;
  wire writes_reg = writes_flags && !is_cmp && (op != cabx_pkg::OP_ZERO_SIGN_CHECK);
  wire moves_pc = (op != cabx_pkg::OP_NOP);

  // ----------------------------------------------------------------
  // Result word
  // ----------------------------------------------------------------
  // Only the strobes are gated by a take; the data fields follow the request
  // every cycle, which keeps the gating out of the wide paths.
  cabx_pkg::cabx_res_t res_next;
  always_comb begin
    res_next = '0;
    res_next.wr_en = take && writes_reg;
    res_next.wr_data = alu_r;
    res_next.pc_valid = take && moves_pc;
    res_next.pc = pc_new;
    res_next.push = take && is_call;
    res_next.ret_addr = pc_seq;
    res_next.io_wr = take && is_iobit && !io_blocked;
    res_next.io_addr = req.io_addr;
    res_next.io_data = io_new;
    res_next.io_refused = take && is_iobit && io_blocked;
  end

  // External loads yield to an instruction that updates flags in the same cycle.
  logic [7:0] status_next;
  assign status_next = (take && writes_flags) ? flags_arith : status_wr ? status_wdata : status_register;

  // ----------------------------------------------------------------
  // Stall sequencer
  // ----------------------------------------------------------------
  // The ready output is registered from state_next, so the cycle right after
  // a multi-clock take already shows not ready and no request slips in.
  cabx_pkg::cabx_state_t state_reg;
  cabx_pkg::cabx_state_t state_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      cabx_pkg::ST_IDLE: begin
        if (take && cycles != cabx_pkg::CYC_ONE) begin
          state_next = cabx_pkg::ST_STALL;
          cnt_next = cycles - cabx_pkg::CYC_ONE;
        end
      end
      cabx_pkg::ST_STALL: begin
        cnt_next = cnt_reg - cabx_pkg::CYC_ONE;
        if (cnt_reg == cabx_pkg::CYC_ONE) begin
          state_next = cabx_pkg::ST_IDLE;
        end
      end
      // An illegal state code falls back to idle rather than locking the stage.
      default: begin
        state_next = cabx_pkg::ST_IDLE;
        cnt_next = 3'h0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= cabx_pkg::ST_IDLE;
      cnt_reg <= 3'h0;
      in_ready <= 1'b1;
      res <= '0;
      status_register <= cabx_pkg::STATUS_RST;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      in_ready <= (state_next == cabx_pkg::ST_IDLE);
      res <= res_next;
      status_register <= status_next;
    end
  end

endmodule : cabx_execute

// *** verilog/cabx_pkg.sv ***
// Shared types and constants for the execute stage of the 8-bit core.
// Assumes a decoder upstream that fills one request word per instruction.
package cabx_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W = 22;
  localparam int OFF_W = 7;
  localparam int IO_A_W = 6;

  // ----------------------------------------------------------------
  // Status register bit positions
  // ----------------------------------------------------------------
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // ----------------------------------------------------------------
  // Constants of the logic
  // ----------------------------------------------------------------
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [IO_A_W-1:0] IO_NOBIT_LO = 6'h08;
  localparam logic [IO_A_W-1:0] IO_NOBIT_HI = 6'h0e;
  localparam logic [PC_W-1:0] PC_STEP = 22'h000001;
  localparam logic [PC_W-1:0] PC_SKIP1 = 22'h000002;
  localparam logic [PC_W-1:0] PC_SKIP2 = 22'h000003;

  // ----------------------------------------------------------------
  // Clock counts per instruction
  // ----------------------------------------------------------------
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam int CALL_CYC_DEF = 3;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_NOP, OP_SUM, OP_SUM_CARRY, OP_DIFFERENCE, OP_DIFFERENCE_IMMEDIATE,
    OP_DIFFERENCE_WITH_BORROW, OP_DIFFERENCE_IMMEDIATE_BORROW,
    OP_CONJUNCTION, OP_BITWISE_CONJUNCTION_IMMEDIATE, OP_DISJUNCTION,
    OP_BITWISE_DISJUNCTION_IMMEDIATE, OP_BITWISE_EXCLUSIVE_DISJUNCTION,
    OP_MASK_SET_BITS, OP_MASK_CLEAR_BITS, OP_ZERO_SIGN_CHECK,
    OP_JUMP_VIA_POINTER, OP_CALL_VIA_POINTER, OP_COMPARE_SKIP_EQUAL,
    OP_COMPARE_REGISTERS, OP_COMPARE_WITH_BORROW, OP_COMPARE_IMMEDIATE,
    OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR,
    OP_SKIP_IO_BIT_SET, OP_BRANCH_STATUS_BIT_SET, OP_BRANCH_STATUS_BIT_CLEAR,
    OP_BRANCH_UNSIGNED_GE, OP_BRANCH_UNSIGNED_LT, OP_BRANCH_SIGNED_GE,
    OP_BRANCH_SIGNED_LT, OP_BRANCH_HALF_CARRY_SET, OP_BRANCH_HALF_CARRY_CLEAR,
    OP_BRANCH_COPY_FLAG_SET, OP_BRANCH_COPY_FLAG_CLEAR, OP_BRANCH_OVERFLOW_SET,
    OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED,
    OP_IO_BIT_SET_OP, OP_IO_BIT_CLEAR_OP
  } cabx_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_STALL = 2'b10
  } cabx_state_t;

  // ----------------------------------------------------------------
  // Request and result words
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    cabx_op_t op;
    logic [7:0] rd;
    logic [7:0] rr;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic [IO_A_W-1:0] io_addr;
    logic [7:0] io_data;
    logic [OFF_W-1:0] offset;
    logic [15:0] pointer;
    logic [PC_W-1:0] pc;
    logic next_two_words;
  } cabx_req_t;

  typedef struct packed {
    logic wr_en;
    logic [7:0] wr_data;
    logic pc_valid;
    logic [PC_W-1:0] pc;
    logic push;
    logic [PC_W-1:0] ret_addr;
    logic io_wr;
    logic [IO_A_W-1:0] io_addr;
    logic [7:0] io_data;
    logic io_refused;
  } cabx_res_t;

endpackage : cabx_pkg
